// ==== hw/tbp_pkg.sv ====
// package of constants for the transmit buffer command parser
package tbp_pkg;
	localparam int DATA_W      = 32;
	localparam int LEN_W       = 11;
	localparam int OFS_W       = 2;
	localparam int FIFO_DEPTH  = 8;
	// first command word fields
	localparam int A_OFS_HI    = 17;
	localparam int A_OFS_LO    = 16;
	localparam int A_FIRST_BIT = 13;
	localparam int A_LAST_BIT  = 12;
	localparam int A_LEN_HI    = 10;
	localparam int A_LEN_LO    = 0;
	// second command word fields
	localparam int B_CSUM_BIT  = 14;
	localparam int B_LEN_HI    = 10;
	localparam int B_LEN_LO    = 0;
	localparam logic [DATA_W-1:0] B_CMP_MASK = 32'hFFFF_BFFF;
	localparam logic [3:0]        BE_ALL     = 4'hF;
	localparam logic [LEN_W-1:0]  LEN_ZERO   = 11'h000;
	localparam logic [LEN_W+1:0]  BYTES_WORD = 13'h0004;
	typedef enum logic [3:0] {
		TBP_CMD_A = 4'b0001,
		TBP_CMD_B = 4'b0010,
		TBP_DATA  = 4'b0100,
		TBP_SKIP  = 4'b1000
	} tbp_state_t;
endpackage : tbp_pkg

// ==== hw/tbp_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module tbp_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	assign in_ready  = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rp_r];

	always_comb begin
		wp_nxt  = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
		rp_nxt  = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule : tbp_fifo

// ==== hw/tbp_parser.sv ====
// transmit buffer command parser: strips command words, forms byte enables, checks frames
// Operation
// RULE_01 - first word bits 17:16 give offset 0..3 of first payload byte
// RULE_02 - first word bit 13 set opens a new frame
// RULE_03 - first word bit 12 set marks the frame's last buffer
// RULE_04 - first word bits 10:0 count payload bytes after the command words
// RULE_05 - offset plus count gives trailing filler bytes, which are not sent
// RULE_06 - buffer counts summed per frame, compared with frame length, error on mismatch
// RULE_07 - host count excludes leading offset and trailing filler bytes
// RULE_08 - checksum only when request bit, opening flag and engine enable all set
// RULE_09 - reserved bits written zero by host and ignored here
// RULE_10 - second word identical across frame except checksum bit, else error
// RULE_11 - second word bits 10:0 hold frame length, same in every buffer
// RULE_12 - offsets 0..3 select lanes 7:0, 15:8, 23:16, 31:24 first
`timescale 1ns/10ps
module tbp_parser
	import tbp_pkg::*;
#(
	parameter int FIFO_DEPTH_P = tbp_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	// word stream from the transmit fifo
	input  wire logic                      in_valid,
	output logic                           in_ready,
	input  wire logic [tbp_pkg::DATA_W-1:0] in_data,
	// configuration
	input  wire logic                      tx_checksum_engine_enable,
	// byte-enabled words towards the mac
	output logic                           out_valid,
	input  wire logic                      out_ready,
	output logic      [tbp_pkg::DATA_W-1:0] out_data,
	output logic      [3:0]                out_be,
	output logic                           out_sof,
	output logic                           out_eof,
	// status
	output logic                           csum_request,
	output logic                           transmit_error_flag,
	input  wire logic                      error_clear
);
	import tbp_pkg::*;

	tbp_state_t        st_r, st_nxt;
	logic [OFS_W-1:0]  ofs_r, ofs_nxt;
	logic              first_r, first_nxt, last_r, last_nxt;
	logic              sof_pend_r, sof_pend_nxt;
	logic [LEN_W+1:0]  rem_r, rem_nxt;
	logic [LEN_W+1:0]  tot_r, tot_nxt;
	logic              in_frame_r, in_frame_nxt;
	logic [DATA_W-1:0] cmdb_r, cmdb_nxt;
	logic [LEN_W-1:0]  flen_r, flen_nxt;
	logic              err_r, err_nxt;
	logic              csum_r, csum_nxt;

	// one word of payload after the offset is applied
	logic              take;
	logic              f_in_ready;
	logic              f_push;
	logic [3:0]        be_lead, be_word;
	logic [LEN_W+1:0]  lane_cnt;
	logic [LEN_W+1:0]  span;
	logic [LEN_W+1:0]  run_tot;
	logic [LEN_W+1:0]  frame_len;
	logic [DATA_W+5:0] f_in;
	logic [DATA_W+5:0] f_out;

	// command words never wait; only payload can back up behind a full fifo
	assign take     = in_valid && in_ready;
	assign in_ready = (st_r != TBP_DATA) || f_in_ready;

	// first lane used in this word; the offset only shifts the opening word
	always_comb begin
		be_lead = BE_ALL << ofs_r; // RULE_12 RULE_01
		lane_cnt = BYTES_WORD - (LEN_W+2)'(ofs_r);
		be_word = be_lead;
		if (rem_r < lane_cnt) begin
			// trailing filler lanes are dropped in the last word
			be_word = be_lead & ~(BE_ALL << (ofs_r + rem_r[1:0])); // RULE_05
		end
		span = (rem_r < lane_cnt) ? rem_r : lane_cnt;
	end

	// running frame total with this buffer, and the length it must reach
	always_comb begin
		run_tot   = first_r ? rem_r : tot_r + rem_r;
		frame_len = first_r ? (LEN_W+2)'(in_data[B_LEN_HI:B_LEN_LO]) : (LEN_W+2)'(flen_r);
	end

	// sof and eof travel with their word so a stalled mac cannot misalign them
	assign f_push = (st_r == TBP_DATA) && take;
	assign f_in   = {be_word, sof_pend_r, last_r && (rem_r == span), in_data};

	always_comb begin
		st_nxt       = st_r;
		ofs_nxt      = ofs_r;
		first_nxt    = first_r;
		last_nxt     = last_r;
		sof_pend_nxt = sof_pend_r;
		rem_nxt      = rem_r;
		tot_nxt      = tot_r;
		in_frame_nxt = in_frame_r;
		cmdb_nxt     = cmdb_r;
		flen_nxt     = flen_r;
		err_nxt      = err_r;
		csum_nxt     = csum_r;
		if (error_clear) begin
			err_nxt = 1'b0;
		end
		unique case (st_r)
			TBP_CMD_A: begin
				if (take) begin
					// reserved bits 31:18, 15:14 and 11 are not looked at
					ofs_nxt   = in_data[A_OFS_HI:A_OFS_LO]; // RULE_01 RULE_09
					first_nxt = in_data[A_FIRST_BIT]; // RULE_02
					last_nxt  = in_data[A_LAST_BIT]; // RULE_03
					rem_nxt   = (LEN_W+2)'(in_data[A_LEN_HI:A_LEN_LO]); // RULE_04 RULE_07
					st_nxt    = TBP_CMD_B;
				end
			end
			TBP_CMD_B: begin
				if (take) begin
					if (first_r) begin
						// a new frame starts; an open frame that never closed is an error
						if (in_frame_r) err_nxt = 1'b1; // RULE_02
						tot_nxt      = rem_r;
						cmdb_nxt     = in_data;
						flen_nxt     = in_data[B_LEN_HI:B_LEN_LO]; // RULE_11
						sof_pend_nxt = 1'b1;
						// only the opening buffer's request counts; later ones may differ
						csum_nxt     = in_data[B_CSUM_BIT] && tx_checksum_engine_enable; // RULE_08
					end else begin
						if (!in_frame_r) err_nxt = 1'b1;
						if ((in_data & B_CMP_MASK) != (cmdb_r & B_CMP_MASK)) err_nxt = 1'b1; // RULE_10 RULE_11
						tot_nxt = tot_r + rem_r; // RULE_06
					end
					// a zero-sized buffer means host and parser are out of step
					if (rem_r[LEN_W-1:0] == LEN_ZERO) err_nxt = 1'b1; // RULE_04
					in_frame_nxt = !last_r; // RULE_03
					st_nxt = (rem_r == '0) ? TBP_CMD_A : TBP_DATA;
				end
			end
			TBP_DATA: begin
				if (take) begin
					sof_pend_nxt = 1'b0;
					ofs_nxt      = '0;
					rem_nxt      = rem_r - span;
					if (rem_r == span) begin
						st_nxt = TBP_CMD_A;
					end
				end
			end
			TBP_SKIP: begin
				// never entered; a stray code goes back to command parsing
				st_nxt = TBP_CMD_A;
			end
			default: begin
				st_nxt = TBP_CMD_A;
			end
		endcase
		// frame total checked once each buffer's command words are in
		if ((st_r == TBP_CMD_B) && take) begin
			// the closing buffer must land exactly on the frame length
			if (last_r && (run_tot != frame_len)) err_nxt = 1'b1; // RULE_06
			// a frame that already reached its length should have closed here
			if (!last_r && (run_tot >= frame_len)) err_nxt = 1'b1; // RULE_03 RULE_06
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r       <= TBP_CMD_A;
			ofs_r      <= '0;
			first_r    <= 1'b0;
			last_r     <= 1'b0;
			sof_pend_r <= 1'b0;
			rem_r      <= '0;
			tot_r      <= '0;
			in_frame_r <= 1'b0;
			cmdb_r     <= '0;
			flen_r     <= '0;
			err_r      <= 1'b0;
			csum_r     <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			ofs_r      <= ofs_nxt;
			first_r    <= first_nxt;
			last_r     <= last_nxt;
			sof_pend_r <= sof_pend_nxt;
			rem_r      <= rem_nxt;
			tot_r      <= tot_nxt;
			in_frame_r <= in_frame_nxt;
			cmdb_r     <= cmdb_nxt;
			flen_r     <= flen_nxt;
			err_r      <= err_nxt;
			csum_r     <= csum_nxt;
		end
	end

	// fifo decouples the parser from mac stalls; a full fifo stalls only payload input, not command words
	tbp_fifo #(
		.WIDTH (DATA_W + 6),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (f_push),
		.in_ready  (f_in_ready),
		.in_data   (f_in),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (f_out)
	);

	// data is passed unshifted; the mac uses the byte enables to pick lanes
	assign out_be              = f_out[DATA_W+5:DATA_W+2];
	assign out_sof             = f_out[DATA_W+1];
	assign out_eof             = f_out[DATA_W];
	assign out_data            = f_out[DATA_W-1:0];
	assign csum_request        = csum_r;
	assign transmit_error_flag = err_r;
endmodule : tbp_parser

// ==== verif/tbp_parser_chk.sv ====
// port checks for the transmit buffer command parser
`timescale 1ns/10ps
module tbp_parser_chk (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// input side
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic [31:0] in_data,
	input wire logic        tx_checksum_engine_enable,
	// output side
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [31:0] out_data,
	input wire logic [3:0]  out_be,
	input wire logic        out_sof,
	input wire logic        out_eof,
	// status
	input wire logic        csum_request,
	input wire logic        transmit_error_flag,
	input wire logic        error_clear
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_reset_idle: assert property (disable iff (1'b0) rst |=> !out_valid && !transmit_error_flag && !csum_request)
		else $error("not idle after reset");
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_be)
		&& $stable({out_sof, out_eof})) else $error("output word not held");
	a_be_shape: assert property (out_valid |-> out_be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC,
		4'hE, 4'hF}) else $error("byte enables not contiguous");
	a_no_spont: assert property (!out_valid && !(in_valid && in_ready) |=> !out_valid)
		else $error("word out without word in");
	a_ready_empty: assert property (!out_valid |-> in_ready)
		else $error("refused while empty");
	a_err_sticky: assert property (transmit_error_flag && !error_clear |=> transmit_error_flag)
		else $error("error flag dropped");
	a_err_clear: assert property (error_clear && !in_valid |=> !transmit_error_flag)
		else $error("error flag not cleared");
	a_err_cause: assert property (!transmit_error_flag && !(in_valid && in_ready) |=> !transmit_error_flag)
		else $error("error without word");
	a_csum_gate: assert property ($rose(csum_request) |-> $past(tx_checksum_engine_enable))
		else $error("checksum without enable");
endmodule : tbp_parser_chk
bind tbp_parser tbp_parser_chk chk_u (.sys_clk, .rst, .in_valid, .in_ready, .tx_checksum_engine_enable, .in_data,
	.out_valid, .out_ready, .out_sof, .out_eof, .csum_request, .transmit_error_flag, .error_clear, .out_data, .out_be);

// ==== verif/tbp_host.sv ====
// host driver model: queues command words and payload, offers them in order
`timescale 1ns/10ps
module tbp_host (
	// clock
	input  wire logic        sys_clk,
	// handshake towards the parser
	input  wire logic        in_ready,
	output logic             in_valid = 1'b0,
	output logic      [31:0] in_data = 32'h0000_0000,
	// pacing
	input  wire logic        slow
);
	logic [31:0] q[$];
	task automatic buf_send(input logic [1:0] ofs, input logic fs, ls, input logic [10:0] cnt, input logic [31:0] b);
		q.push_back({14'h0000, ofs, 2'b00, fs, ls, 1'b0, cnt});
		q.push_back(b);
		// payload word j of a buffer carries j, so the bench can predict it
		for (int j = 0; j < (ofs + cnt + 3) / 4; j++) q.push_back(32'hA5A5_0000 + j);
	endtask : buf_send
	// slow mode idles one cycle after each take; an offered word is never withdrawn
	always @(posedge sys_clk) begin
		if (in_valid && in_ready)
			void'(q.pop_front());
		if (q.size() > 0 && (!slow || !in_valid || !in_ready)) begin
			in_valid <= 1'b1;
			in_data <= q[0];
		end else begin
			in_valid <= 1'b0;
			in_data <= ~in_data;
		end
	end
endmodule : tbp_host

// ==== verif/tb_tbp_parser.sv ====
// self-checking bench for the transmit buffer command parser
`timescale 1ns/10ps
module tb_tbp_parser;
	logic        sys_clk = 1'b0, rst = 1'b1, slow = 1'b0, cs_en = 1'b0, out_ready = 1'b1, error_clear = 1'b0;
	logic        in_valid, in_ready, out_valid, out_sof, out_eof, csum_request, transmit_error_flag;
	logic [31:0] in_data, out_data;
	logic [3:0]  out_be;
	logic [37:0] got[$];
	int          n_errors = 0, samples_checked = 0;
	always #5 sys_clk = ~sys_clk;
	tbp_parser #(.FIFO_DEPTH_P(8)) dut_u (.sys_clk, .rst, .in_valid, .in_ready, .in_data, .out_valid, .out_ready,
		.tx_checksum_engine_enable(cs_en), .out_data, .out_be, .out_sof, .out_eof, .csum_request,
		.transmit_error_flag, .error_clear);
	tbp_host host_u (.sys_clk, .in_ready, .slow, .in_valid, .in_data);
	always @(posedge sys_clk) if (out_valid && out_ready) got.push_back({out_sof, out_eof, out_be, out_data});
	task automatic check(input logic [37:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// waits a bounded time for the next output word {sof, eof, be, data}
	task automatic pull(input logic [5:0] exp, input logic [31:0] d);
		for (int i = 0; i < 60 && got.size() == 0; i++) @(posedge sys_clk);
		check(got.size() > 0 ? got.pop_front() : 'x, {exp, d});
	endtask : pull
	task automatic settle;
		repeat (30) @(posedge sys_clk);
	endtask : settle
	task automatic t_lanes;
		for (int k = 0; k < 4; k++) begin
			host_u.buf_send(k[1:0], 1'b1, 1'b1, 11'h001, 32'h0000_0001);
			pull({2'b11, 4'h1 << k}, 32'hA5A5_0000);
		end
		host_u.buf_send(2'd1, 1'b1, 1'b1, 11'h005, 32'h0000_0005);
		pull({2'b10, 4'hE}, 32'hA5A5_0000);
		pull({2'b01, 4'h3}, 32'hA5A5_0001);
		slow <= 1'b1;
		host_u.buf_send(2'd0, 1'b1, 1'b0, 11'h004, 32'h0000_0007);
		host_u.buf_send(2'd3, 1'b0, 1'b1, 11'h003, 32'h0000_0007);
		pull({2'b10, 4'hF}, 32'hA5A5_0000);
		pull({2'b00, 4'h8}, 32'hA5A5_0000);
		pull({2'b01, 4'h3}, 32'hA5A5_0001);
		slow <= 1'b0;
		settle();
		check(transmit_error_flag, 1'b0);
	endtask : t_lanes
	task automatic t_csum;
		for (int k = 0; k < 4; k++) begin
			cs_en <= k[0];
			host_u.buf_send(2'd0, 1'b1, 1'b0, 11'h004, {17'h0_0000, k[1], 14'h0008});
			host_u.buf_send(2'd0, 1'b0, 1'b1, 11'h004, {17'h0_0000, !k[1], 14'h0008});
			settle();
			check(csum_request, k[0] & k[1]);
			check(transmit_error_flag, 1'b0);
		end
		got.delete();
	endtask : t_csum
	task automatic t_fill;
		out_ready <= 1'b0;
		host_u.buf_send(2'd0, 1'b1, 1'b1, 11'h028, 32'h0000_0028);
		settle();
		check(in_ready, 1'b0);
		out_ready <= 1'b1;
		pull({2'b10, 4'hF}, 32'hA5A5_0000);
		for (int j = 1; j < 9; j++) pull({2'b00, 4'hF}, 32'hA5A5_0000 + j);
		pull({2'b01, 4'hF}, 32'hA5A5_0009);
		settle();
		check(out_valid, 1'b0);
	endtask : t_fill
	task automatic t_errs;
		for (int k = 0; k < 6; k++) begin
			if (k == 0) host_u.buf_send(2'd0, 1'b1, 1'b1, 11'h003, 32'h0000_0005);
			if (k == 1) host_u.buf_send(2'd0, 1'b1, 1'b1, 11'h000, 32'h0000_0000);
			if (k == 2) host_u.buf_send(2'd0, 1'b1, 1'b0, 11'h004, 32'h0000_0008);
			if (k == 2) host_u.buf_send(2'd0, 1'b0, 1'b1, 11'h004, 32'h0000_2008);
			// opening buffer while a frame is still open
			if (k == 3) host_u.buf_send(2'd0, 1'b1, 1'b0, 11'h004, 32'h0000_0008);
			if (k == 3) host_u.buf_send(2'd0, 1'b1, 1'b1, 11'h004, 32'h0000_0004);
			// continuation buffer with no frame open
			if (k == 4) host_u.buf_send(2'd0, 1'b0, 1'b1, 11'h004, 32'h0000_0004);
			// frame length reached without the closing flag
			if (k == 5) host_u.buf_send(2'd0, 1'b1, 1'b0, 11'h008, 32'h0000_0008);
			settle();
			check(transmit_error_flag, 1'b1);
			error_clear <= 1'b1;
			@(posedge sys_clk);
			error_clear <= 1'b0;
			@(posedge sys_clk);
			check(transmit_error_flag, 1'b0);
			got.delete();
		end
	endtask : t_errs
	task automatic give_verdict;
		if (n_errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_lanes();
		t_csum();
		t_fill();
		t_errs();
		give_verdict();
	end
	initial begin
		#100us;
		n_errors++;
		give_verdict();
	end
endmodule : tb_tbp_parser
